//--- testbench/ssr_i2c_mst.sv
// I2C master model driving SCL and an open-drain SDA.
// Assumes the bench builds the pulled-up SDA wire.
module ssr_i2c_mst (
	// Bus lines
	output logic scl_o,
	output logic sda_o,
	input wire logic sda_i
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int H = 80;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// ======
	// Frames; SCL stands high between them
	task automatic start();
		sda_o = 1'b0;
		#H;
		scl_o = 1'b0;
		#H;
	endtask : start
	task automatic stop();
		sda_o = 1'b0;
		#H;
		scl_o = 1'b1;
		#H;
		sda_o = 1'b1;
		#H;
	endtask : stop
	// One pulse; line sampled mid-high
	task automatic pulse(input logic b, output logic s);
		sda_o = b;
		#H;
		scl_o = 1'b1;
		#(H / 2);
		s = sda_i;
		#(H / 2);
		scl_o = 1'b0;
	endtask : pulse
	task automatic tx(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(v[i], s);
		end
		pulse(1'b1, ack);
		#H;
	endtask : tx
	task automatic rx(input logic nack, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(1'b1, v[i]);
		end
		pulse(nack, s);
		#H;
	endtask : rx
endmodule : ssr_i2c_mst

//--- testbench/ssr_status_sva.sv
// Checker of the status block, bound to its ports.
// Assumes the bus idles high before the first Start.
module ssr_status_sva (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Bus and interrupt
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ======
	// Shadows of written fields
	logic en;
	logic ten;
	logic [1:0] hi;
	logic [7:0] msk;
	logic [1:0] cnd;
	logic [3:0] age;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{en, ten, hi, msk} <= '0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				4'h0: hi <= reg_wdata_i[7:6];
				4'h1: {ten, en} <= reg_wdata_i[1:0];
				4'h5: msk <= reg_wdata_i;
				default: ;
			endcase
		end
	end
	// Last condition, 1 Start and 2 Stop; age hides the sync lag
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnd <= 2'd0;
			age <= 4'd0;
		end else if (reg_wr_i && reg_addr_i == 4'h1) begin
			cnd <= reg_wdata_i[0] ? cnd : 2'd0;
			age <= 4'd0;
		end else if (en && scl_i && $past(scl_i) && $changed(sda_i)) begin
			cnd <= $fell(sda_i) ? 2'd1 : 2'd2;
			age <= 4'd0;
		end else if (age != 4'hF) begin
			age <= age + 4'd1;
		end
	end
	// ======
	// Properties
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence rd_stat;
		reg_rd_i && reg_addr_i == 4'h0 ##1 1'b1;
	endsequence
	sequence rd_old;
		reg_rd_i && reg_addr_i == 4'h0 && age > 4'd7 ##1 1'b1;
	endsequence
	rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data not zero outside read");
	unmapped_zero_a: assert property (reg_rd_i && reg_addr_i > 4'h5 |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	cond_excl_a: assert property (rd_stat |-> !(reg_rdata_o[4] && reg_rdata_o[3]))
		else $error("start and stop both set");
	start_flag_a: assert property (rd_old |-> reg_rdata_o[3] == ($past(cnd) == 2'd1))
		else $error("start flag wrong");
	stop_flag_a: assert property (rd_old |-> reg_rdata_o[4] == ($past(cnd) == 2'd2))
		else $error("stop flag wrong");
	off_quiet_a: assert property (rd_old |-> $past(en) || reg_rdata_o[5:0] == 6'h00)
		else $error("status set while disabled");
	upd_ten_a: assert property (rd_stat |-> $past(ten) || !reg_rdata_o[1])
		else $error("update flag outside 10-bit mode");
	edge_kept_a: assert property (rd_stat |-> reg_rdata_o[7:6] == $past(hi))
		else $error("upper status bits not as written");
	irq_mask_a: assert property (msk == 8'h00 |-> !irq_o)
		else $error("interrupt with all masked");
endmodule : ssr_status_sva

bind ssr_status ssr_status_sva chk (
	.core_clk_i(core_clk_i),
	.rst_n_i(rst_n_i),
	.reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o),
	.scl_i(scl_i),
	.sda_i(sda_i),
	.sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.irq_o(irq_o)
);

//--- testbench/tb_i2c_slave_status_register.sv
// Self-checking bench of the status block with an I2C master model.
// Assumes design, checker and master model are compiled first.
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_i2c_slave_status_register;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i;
	logic rst_n_i;
	logic [3:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	logic reg_wr_i;
	logic reg_rd_i;
	logic [7:0] reg_rdata_o;
	logic scl;
	logic sda_m;
	wire sda_line;
	logic sda_o;
	logic sda_oe_o;
	logic irq_o;
	int err_total = 0;
	int num_checks = 0;
	logic [31:0] lfsr = 32'd75774;
	logic [6:0] sa;
	logic [7:0] d;
	logic [7:0] d2;
	logic ack;
	assign sda_line = sda_m & ~(sda_oe_o & ~sda_o);
	ssr_status dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .irq_o(irq_o));
	ssr_i2c_mst mst (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_line));
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	// ======
	// Helpers
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[7:0];
	endfunction : rnd
	function automatic logic [7:0] st(logic da, p, s, rw, ua, bf);
		return {2'b00, da, p, s, rw, ua, bf};
	endfunction : st
	task automatic wr(logic [3:0] a, logic [7:0] v);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
		// Ends off the clock edge so the master model's pin moves never race the sampler
		@(negedge core_clk_i);
	endtask : wr
	task automatic rd(logic [3:0] a, logic [7:0] e, logic [7:0] m = 8'hFF);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge core_clk_i);
		`CHK(reg_rdata_o & m, e)
	endtask : rd
	task automatic finish_test();
		if (err_total == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		#1000000;
		err_total++;
		finish_test();
	end
	// ======
	// Main sequence
	initial begin
		{reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
		rst_n_i = 1'b0;
		repeat (3) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rd(i[3:0], 8'h00);
		end
		wr(4'h0, 8'hBF);
		rd(4'h0, 8'h80);
		wr(4'h0, 8'h00);
		d = rnd();
		sa = {1'b0, d[5:0]};
		wr(4'h2, {sa, 1'b0});
		wr(4'h5, 8'h0F);
		wr(4'h1, 8'h01);
		mst.start();
		rd(4'h0, st(0, 0, 1, 0, 0, 0));
		mst.tx({sa, 1'b0}, ack);
		`CHK(ack, 1'b0)
		`CHK(irq_o, 1'b1)
		rd(4'h0, st(0, 0, 1, 0, 0, 0));
		rd(4'h4, 8'h05);
		`CHK(irq_o, 1'b0)
		for (int i = 0; i < 3; i++) begin
			d = (i == 0) ? 8'hFF : rnd();
			mst.tx(d, ack);
			rd(4'h0, st(1, 0, 1, 0, 0, 1));
			rd(4'h3, d);
			rd(4'h0, st(1, 0, 1, 0, 0, 0));
		end
		mst.stop();
		rd(4'h0, st(1, 1, 0, 0, 0, 0));
		mst.start();
		mst.tx({sa ^ 7'h01, 1'b0}, ack);
		`CHK(ack, 1'b1)
		mst.stop();
		mst.start();
		mst.tx({sa, 1'b1}, ack);
		rd(4'h0, st(0, 0, 1, 1, 0, 0));
		d = rnd();
		wr(4'h3, d);
		rd(4'h0, st(0, 0, 1, 1, 0, 1));
		mst.rx(1'b1, d2);
		`CHK(d2, d)
		rd(4'h0, st(1, 0, 1, 0, 0, 0), 8'hFB);
		mst.stop();
		wr(4'h1, 8'h00);
		// Let the checker's settle counter run out so the disabled read is watched
		repeat (8) @(posedge core_clk_i);
		rd(4'h0, 8'h00);
		wr(4'h5, 8'h00);
		wr(4'h1, 8'h03);
		d = rnd();
		mst.start();
		mst.tx(8'hF0, ack);
		rd(4'h0, st(0, 0, 1, 0, 1, 0));
		wr(4'h2, d);
		rd(4'h0, st(0, 0, 1, 0, 0, 0));
		mst.tx(d, ack);
		`CHK(ack, 1'b0)
		rd(4'h0, st(0, 0, 1, 0, 1, 0));
		`CHK(irq_o, 1'b0)
		mst.stop();
		finish_test();
	end
endmodule : tb_i2c_slave_status_register

//--- verilog/ssr_cfg.svh
// Offsets, field positions and reset values of the status block.
// Assumes inclusion by bare name from design files only.
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// ==========================================
// Register offsets
`define SSR_OFF_STATUS 4'h0
`define SSR_OFF_CTRL 4'h1
`define SSR_OFF_ADDR 4'h2
`define SSR_OFF_DATA 4'h3
`define SSR_OFF_IRQ_STAT 4'h4
`define SSR_OFF_IRQ_MASK 4'h5

// ==========================================
// Status field positions
`define SSR_BIT_SLEW 7
`define SSR_BIT_EDGE 6
`define SSR_BIT_DATA_ADDR 5
`define SSR_BIT_STOP 4
`define SSR_BIT_START 3
`define SSR_BIT_DIR 2
`define SSR_BIT_UPDATE 1
`define SSR_BIT_FULL 0

// ==========================================
// Control field positions
`define SSR_CTRL_EN 0
`define SSR_CTRL_TEN 1

// ==========================================
// Interrupt status positions
`define SSR_IRQ_START 0
`define SSR_IRQ_STOP 1
`define SSR_IRQ_MATCH 2
`define SSR_IRQ_BYTE 3

// ==========================================
// Reset values
`define SSR_RST_STATUS 8'h00
`define SSR_RST_CTRL 8'h00
`define SSR_RST_ADDR 8'h00
`define SSR_RST_MASK 8'h00

`endif

//--- verilog/ssr_line_mon.sv
// Line monitor: synchronises SCL and SDA and reports Start, Stop and clock edges.
// Assumes SCL and SDA come asynchronously from the bus pins.
module ssr_line_mon (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Bus lines
	input wire logic scl_i,
	input wire logic sda_i,
	// Events
	output ssr_pkg::ssr_line_ev_t ev_o
);

	// ==========================================
	// Synchronisers
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_q;
	logic sda_q;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
		end else begin
			scl_sync <= {scl_sync[0], scl_i};
			sda_sync <= {sda_sync[0], sda_i};
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_sync[1];
			sda_q <= sda_sync[1];
		end
	end

	// ==========================================
	// Edge decode; SDA moving while SCL high marks a condition
	always_comb begin
		ev_o.start = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
		ev_o.stop = scl_sync[1] && scl_q && !sda_q && sda_sync[1];
		ev_o.bit_rise = scl_sync[1] && !scl_q;
		ev_o.bit_fall = !scl_sync[1] && scl_q;
		ev_o.sda = sda_sync[1];
	end

endmodule : ssr_line_mon

//--- verilog/ssr_pkg.sv
// Types shared by the status block and its line monitor.
// Assumes nothing of its surroundings.
package ssr_pkg;

	// ==========================================
	// Bus events seen on the serial lines
	typedef struct packed {
		logic start;
		logic stop;
		logic bit_rise;
		logic bit_fall;
		logic sda;
	} ssr_line_ev_t;

	// ==========================================
	// Byte engine states
	typedef enum logic [4:0] {
		SSR_IDLE = 5'b00001,
		SSR_SHIFT = 5'b00010,
		SSR_ACK = 5'b00100,
		SSR_SEND = 5'b01000,
		SSR_WAIT = 5'b10000
	} ssr_state_t;

endpackage : ssr_pkg

//--- verilog/ssr_status.sv
// Slave status register of the sync_serial_port in I2C mode, with a byte engine.
// Assumes a plain register port on core_clk_i and SCL/SDA from the bus pins.
// ==========================================
`include "ssr_cfg.svh"
module ssr_status (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Bus lines
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Interrupt
	output logic irq_o
);

	// ==========================================
	// Line monitor
	ssr_pkg::ssr_line_ev_t ev;

	ssr_line_mon u_mon (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.ev_o(ev)
	);

	// ==========================================
	// Registers
	logic [7:0] ctrl;
	logic [7:0] slave_address_register;
	logic [7:0] serial_data_buffer;
	logic [7:0] irq_mask;
	logic [7:0] irq_stat;
	logic slew_sample_select;
	logic edge_select;
	logic data_addr;
	logic stop_seen;
	logic start_seen;
	logic dir;
	logic address_update_flag;
	logic buffer_full_flag;
	logic [7:0] serial_port_status;

	// Engine state
	ssr_pkg::ssr_state_t state;
	logic [7:0] shreg;
	logic [3:0] bitcnt;
	logic first_byte;
	logic addressed;
	logic second_addr;
	logic ack_drive;
	logic byte_done;
	logic match_ev;
	logic tx_load;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction : hit

	wire logic enable = ctrl[`SSR_CTRL_EN];
	wire logic ten_bit = ctrl[`SSR_CTRL_TEN];
	wire logic wr_status = reg_wr_i && hit(reg_addr_i, `SSR_OFF_STATUS);
	wire logic rd_data = reg_rd_i && hit(reg_addr_i, `SSR_OFF_DATA);
	wire logic wr_data = reg_wr_i && hit(reg_addr_i, `SSR_OFF_DATA);
	wire logic rd_irq = reg_rd_i && hit(reg_addr_i, `SSR_OFF_IRQ_STAT);
	// First byte with 11110 prefix starts a 10-bit address
	wire logic ten_hdr = ten_bit && (shreg[7:3] == 5'h1E);
	wire logic addr_ok = ten_bit ? (second_addr ? (shreg == slave_address_register) : ten_hdr)
		: (shreg[7:1] == slave_address_register[7:1]);

	always_comb begin
		serial_port_status = 8'h00;
		serial_port_status[`SSR_BIT_SLEW] = slew_sample_select;
		serial_port_status[`SSR_BIT_EDGE] = edge_select;
		serial_port_status[`SSR_BIT_DATA_ADDR] = data_addr;
		serial_port_status[`SSR_BIT_STOP] = stop_seen;
		serial_port_status[`SSR_BIT_START] = start_seen;
		serial_port_status[`SSR_BIT_DIR] = dir;
		serial_port_status[`SSR_BIT_UPDATE] = address_update_flag;
		serial_port_status[`SSR_BIT_FULL] = buffer_full_flag;
	end

	// ==========================================
	// Software-written registers
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl <= `SSR_RST_CTRL;
			slave_address_register <= `SSR_RST_ADDR;
			irq_mask <= `SSR_RST_MASK;
			slew_sample_select <= 1'b0;
			edge_select <= 1'b0;
		end else if (reg_wr_i) begin
			if (hit(reg_addr_i, `SSR_OFF_CTRL))
				ctrl <= reg_wdata_i;
			if (hit(reg_addr_i, `SSR_OFF_ADDR))
				slave_address_register <= reg_wdata_i;
			if (hit(reg_addr_i, `SSR_OFF_IRQ_MASK))
				irq_mask <= reg_wdata_i;
			if (wr_status) begin
				slew_sample_select <= reg_wdata_i[`SSR_BIT_SLEW];
				// Stored as written; software is expected to leave it clear
				edge_select <= reg_wdata_i[`SSR_BIT_EDGE];
			end
		end
	end

	// ==========================================
	// Bus condition flags
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stop_seen <= 1'b0;
			start_seen <= 1'b0;
		end else if (!enable) begin
			stop_seen <= 1'b0;
			start_seen <= 1'b0;
		end else if (ev.start) begin
			start_seen <= 1'b1;
			stop_seen <= 1'b0;
		end else if (ev.stop) begin
			stop_seen <= 1'b1;
			start_seen <= 1'b0;
		end
	end

	// ==========================================
	// Byte engine
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ssr_pkg::SSR_IDLE;
			shreg <= 8'h00;
			bitcnt <= 4'h0;
			first_byte <= 1'b0;
			addressed <= 1'b0;
			second_addr <= 1'b0;
			ack_drive <= 1'b0;
		end else if (!enable || ev.stop) begin
			state <= ssr_pkg::SSR_IDLE;
			addressed <= 1'b0;
			second_addr <= 1'b0;
			ack_drive <= 1'b0;
		end else if (ev.start) begin
			// Repeated Start keeps the 10-bit header state for reads
			state <= ssr_pkg::SSR_SHIFT;
			bitcnt <= 4'h0;
			first_byte <= 1'b1;
			addressed <= 1'b0;
			ack_drive <= 1'b0;
		end else begin
			case (state)
				ssr_pkg::SSR_IDLE: begin
					ack_drive <= 1'b0;
				end
				ssr_pkg::SSR_SHIFT: begin
					if (ev.bit_rise) begin
						shreg <= {shreg[6:0], ev.sda};
						bitcnt <= bitcnt + 4'h1;
					end else if (ev.bit_fall && bitcnt == 4'h8) begin
						bitcnt <= 4'h0;
						state <= ssr_pkg::SSR_ACK;
						if (first_byte || second_addr) begin
							ack_drive <= addr_ok;
							addressed <= addr_ok && !(ten_bit && !second_addr && !shreg[0]);
							second_addr <= ten_bit && addr_ok && !second_addr && !shreg[0];
						end else begin
							ack_drive <= addressed && !dir;
						end
						if (!second_addr)
							first_byte <= 1'b0;
					end
				end
				ssr_pkg::SSR_ACK: begin
					if (ev.bit_fall) begin
						ack_drive <= 1'b0;
						if (!addressed && !second_addr)
							state <= ssr_pkg::SSR_IDLE;
						else if (addressed && dir)
							state <= ssr_pkg::SSR_WAIT;
						else
							state <= ssr_pkg::SSR_SHIFT;
					end else if (ev.bit_rise && addressed && dir && ev.sda && !ack_drive) begin
						// Master NACK ends the transmission
						state <= ssr_pkg::SSR_IDLE;
					end
				end
				ssr_pkg::SSR_WAIT: begin
					// Stretch-free: waits for software to load the buffer
					if (buffer_full_flag) begin
						shreg <= serial_data_buffer;
						state <= ssr_pkg::SSR_SEND;
					end
				end
				ssr_pkg::SSR_SEND: begin
					if (ev.bit_fall) begin
						shreg <= {shreg[6:0], 1'b1};
						bitcnt <= bitcnt + 4'h1;
						if (bitcnt == 4'h7) begin
							bitcnt <= 4'h0;
							state <= ssr_pkg::SSR_ACK;
						end
					end
				end
				default: state <= ssr_pkg::SSR_IDLE;
			endcase
		end
	end

	assign byte_done = (state == ssr_pkg::SSR_SHIFT) && ev.bit_fall && (bitcnt == 4'h8);
	assign match_ev = byte_done && (first_byte || second_addr) && addr_ok;
	assign tx_load = wr_data && (state == ssr_pkg::SSR_WAIT || dir);

	// ==========================================
	// Status capture
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_addr <= 1'b0;
			dir <= 1'b0;
			address_update_flag <= 1'b0;
		end else if (!enable) begin
			data_addr <= 1'b0;
			dir <= 1'b0;
			address_update_flag <= 1'b0;
		end else begin
			if (byte_done)
				data_addr <= !(first_byte || second_addr);
			else if (state == ssr_pkg::SSR_SEND && ev.bit_fall && bitcnt == 4'h7)
				data_addr <= 1'b1;
			if (match_ev && !second_addr)
				dir <= shreg[0];
			// Direction holds past its valid window; the register is not cleared then
			if (match_ev && ten_bit)
				address_update_flag <= 1'b1;
			else if (reg_wr_i && hit(reg_addr_i, `SSR_OFF_ADDR))
				address_update_flag <= 1'b0;
		end
	end

	// ==========================================
	// Data buffer and full flag
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			serial_data_buffer <= 8'h00;
			buffer_full_flag <= 1'b0;
		end else if (!enable) begin
			buffer_full_flag <= 1'b0;
		end else if (byte_done && !first_byte && !second_addr && addressed) begin
			serial_data_buffer <= shreg;
			buffer_full_flag <= 1'b1;
		end else if (tx_load) begin
			serial_data_buffer <= reg_wdata_i;
			buffer_full_flag <= 1'b1;
		end else if (rd_data && !dir) begin
			buffer_full_flag <= 1'b0;
		end else if (state == ssr_pkg::SSR_SEND && ev.bit_fall && bitcnt == 4'h7) begin
			buffer_full_flag <= 1'b0;
		end
	end

	// ==========================================
	// Interrupts; a new event beats the read that clears
	logic [7:0] irq_set;

	always_comb begin
		irq_set = 8'h00;
		irq_set[`SSR_IRQ_START] = enable && ev.start;
		irq_set[`SSR_IRQ_STOP] = enable && ev.stop;
		irq_set[`SSR_IRQ_MATCH] = enable && match_ev;
		irq_set[`SSR_IRQ_BYTE] = enable && byte_done && addressed;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			irq_stat <= 8'h00;
		else
			irq_stat <= (rd_irq ? 8'h00 : irq_stat) | irq_set;
	end

	assign irq_o = |(irq_stat & irq_mask);

	// ==========================================
	// Read port and SDA drive
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`SSR_OFF_STATUS: reg_rdata_o <= serial_port_status;
				`SSR_OFF_CTRL: reg_rdata_o <= ctrl;
				`SSR_OFF_ADDR: reg_rdata_o <= slave_address_register;
				`SSR_OFF_DATA: reg_rdata_o <= serial_data_buffer;
				`SSR_OFF_IRQ_STAT: reg_rdata_o <= irq_stat;
				`SSR_OFF_IRQ_MASK: reg_rdata_o <= irq_mask;
				default: reg_rdata_o <= 8'h00;
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	// Open-drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_o = ack_drive || (state == ssr_pkg::SSR_SEND && !shreg[7]);

endmodule : ssr_status
